/* File: dou_pkg.sv */
/*
 * Package for the data operation unit: register offsets, field positions,
 * reset values and mode encodings.
 * Assumes a simple strobe register port with word addresses.
 */
package dou_pkg;
    // ==========================================================
    // register offsets (word index on the plain port)
    localparam logic [2:0] DOU_OFS_CONTROL   = 3'h0;
    localparam logic [2:0] DOU_OFS_STATUS    = 3'h1;
    localparam logic [2:0] DOU_OFS_STAT_CLR  = 3'h2;
    localparam logic [2:0] DOU_OFS_OPERAND   = 3'h3;
    localparam logic [2:0] DOU_OFS_REF_ZERO  = 3'h4;
    localparam logic [2:0] DOU_OFS_REF_ONE   = 3'h5;
    localparam logic [2:0] DOU_OFS_RESULT    = 3'h6;
    localparam int         DOU_ADDR_W        = 3;

    // ==========================================================
    // control field positions
    localparam int DOU_CTL_MODE_LSB  = 0;   // bits 1..0 operation mode
    localparam int DOU_CTL_SIZE_BIT  = 3;   // operation_size_select
    localparam int DOU_CTL_COND_LSB  = 4;   // bits 6..4 detect_condition_select
    localparam int DOU_CTL_IRQ_BIT   = 7;   // operation_irq_enable
    localparam int DOU_CTL_STOP_BIT  = 8;   // module stop
    localparam logic [8:0] DOU_CTL_RESET = 9'h100;  // stopped after reset

    // status bit positions
    localparam int DOU_ST_CMP   = 0;
    localparam int DOU_ST_OVF   = 1;
    localparam int DOU_ST_UDF   = 2;
    localparam int DOU_ST_BAD   = 3;

    // ==========================================================
    typedef enum logic [1:0] {
        DOU_OP_COMPARE  = 2'h0,
        DOU_OP_ADD      = 2'h1,
        DOU_OP_SUB      = 2'h2,
        DOU_OP_RSVD     = 2'h3
    } dou_op_t;

    typedef enum logic [2:0] {
        DOU_C_MISMATCH  = 3'h0,
        DOU_C_MATCH     = 3'h1,
        DOU_C_LESS      = 3'h2,
        DOU_C_GREATER   = 3'h3,
        DOU_C_INRANGE   = 3'h4,
        DOU_C_OUTRANGE  = 3'h5
    } dou_cond_t;

    typedef enum logic [1:0] {
        DOU_S_IDLE  = 2'b00,
        DOU_S_CALC  = 2'b01,
        DOU_S_DONE  = 2'b11
    } dou_state_t;
endpackage : dou_pkg

/* File: dou_op_if.sv */
/*
 * Interface between the unit's register side and its arithmetic core.
 * Assumes both ends share clk_sys.
 */
`timescale 1ns/1ns
`default_nettype none
interface dou_op_if #(parameter int W = 32);
    logic [W-1:0] operand;
    logic [W-1:0] ref_zero;
    logic [W-1:0] ref_one;
    logic         wide;
    logic [1:0]   op;
    logic [2:0]   cond;
    logic [W-1:0] result;
    logic         hit;
    logic         ovf;
    logic         udf;
    logic         bad;
    modport ctrl (output operand, ref_zero, ref_one, wide, op, cond,
                  input result, hit, ovf, udf, bad);
    modport core (input operand, ref_zero, ref_one, wide, op, cond,
                  output result, hit, ovf, udf, bad);
endinterface : dou_op_if
`default_nettype wire

/* File: dou_core.sv */
/*
 * Combinational compare/add/subtract core of the data operation unit.
 * Assumes the caller registers everything it drives and reads.
 */
`timescale 1ns/1ns
`default_nettype none
module dou_core
    import dou_pkg::*;
#(
    parameter int W = 32
) (
    dou_op_if.core  bus
);
    logic [W-1:0] a;
    logic [W-1:0] r0;
    logic [W-1:0] r1;
    logic [W:0]   sum;
    logic [W:0]   diff;

    // ==========================================================
    // narrow operands to 16 bits when the size bit is clear
    always_comb begin
        a  = bus.wide ? bus.operand  : {16'h0000, bus.operand[15:0]};
        r0 = bus.wide ? bus.ref_zero : {16'h0000, bus.ref_zero[15:0]};
        r1 = bus.wide ? bus.ref_one  : {16'h0000, bus.ref_one[15:0]};
        sum  = {1'b0, a} + {1'b0, r0};
        diff = {1'b0, a} - {1'b0, r0};
    end

    // carry out of bit 15 or bit 31 flags wrap
    always_comb begin
        bus.result = '0;
        bus.hit    = 1'b0;
        bus.ovf    = 1'b0;
        bus.udf    = 1'b0;
        bus.bad    = 1'b0;
        case (dou_op_t'(bus.op))
            DOU_OP_COMPARE: begin
                case (dou_cond_t'(bus.cond))
                    DOU_C_MISMATCH: bus.hit = (a != r0);
                    DOU_C_MATCH:    bus.hit = (a == r0);
                    DOU_C_LESS:     bus.hit = (a < r0);
                    DOU_C_GREATER:  bus.hit = (a > r0);
                    DOU_C_INRANGE:  bus.hit = (a > r0) && (a < r1);
                    DOU_C_OUTRANGE: bus.hit = (a < r0) || (a > r1);
                    default:        bus.bad = 1'b1;   // prohibited code
                endcase
                bus.result = a;
            end
            DOU_OP_ADD: begin
                bus.result = bus.wide ? sum[W-1:0] : {16'h0000, sum[15:0]};
                bus.ovf    = bus.wide ? sum[W] : sum[16];
            end
            DOU_OP_SUB: begin
                bus.result = bus.wide ? diff[W-1:0] : {16'h0000, diff[15:0]};
                bus.udf    = bus.wide ? diff[W] : diff[16];
            end
            default: bus.bad = 1'b1;
        endcase
    end
endmodule : dou_core
`default_nettype wire

/* File: dou_unit.sv */
/*
 * Data operation unit: registers, operation sequencing, flags, interrupt
 * request and event output. Assumes a plain strobe register port whose
 * read data is consumed in the cycle after the read strobe.
 */
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module dou_unit
    import dou_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic [DOU_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    output logic                       irq_req,
    output logic                       event_out,
    output logic                       module_stopped
);
    logic [8:0]       control;
    logic [W-1:0]     operand;
    logic [W-1:0]     ref_zero;
    logic [W-1:0]     ref_one;
    logic [W-1:0]     result;
    logic [3:0]       status;
    dou_state_t       state;
    dou_state_t       next_state;
    logic [3:0]       event_set;
    logic             stop;
    logic             wr_ctl;
    logic             wr_opnd;
    logic             wr_clr;

    dou_op_if #(.W(W)) op_bus ();

    dou_core #(.W(W)) i_dou_core (
        .bus (op_bus.core)
    );

    // ==========================================================
    // register decode
    assign stop    = control[DOU_CTL_STOP_BIT];
    assign wr_ctl  = reg_wr && (reg_addr == DOU_OFS_CONTROL);
    assign wr_opnd = reg_wr && (reg_addr == DOU_OFS_OPERAND) && !stop;
    assign wr_clr  = reg_wr && (reg_addr == DOU_OFS_STAT_CLR);

    // control register; the stop bit stays writable while stopped
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            control <= DOU_CTL_RESET;
        end else if (wr_ctl) begin
            control <= reg_wdata[8:0];
        end
    end

    // data registers are frozen in module stop to save power
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ref_zero <= '0;
            ref_one  <= '0;
        end else if (reg_wr && !stop) begin
            if (reg_addr == DOU_OFS_REF_ZERO) begin
                ref_zero <= reg_wdata[W-1:0];
            end
            if (reg_addr == DOU_OFS_REF_ONE) begin
                ref_one <= reg_wdata[W-1:0];
            end
        end
    end

    // operand write latches the value; the core evaluates next cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            operand <= '0;
        end else if (wr_opnd) begin
            operand <= reg_wdata[W-1:0];
        end
    end

    // ==========================================================
    // core inputs come straight from registers
    assign op_bus.operand  = operand;
    assign op_bus.ref_zero = ref_zero;
    assign op_bus.ref_one  = ref_one;
    assign op_bus.wide     = control[DOU_CTL_SIZE_BIT];
    assign op_bus.op       = control[DOU_CTL_MODE_LSB +: 2];
    assign op_bus.cond     = control[DOU_CTL_COND_LSB +: 3];

    // sequencer: one evaluation per operand write
    always_comb begin
        next_state = state;
        case (state)
            DOU_S_IDLE: if (wr_opnd) begin
                next_state = DOU_S_CALC;
            end
            // a write landing in the evaluation cycle must not be lost
            DOU_S_CALC: next_state = wr_opnd ? DOU_S_CALC : DOU_S_DONE;
            DOU_S_DONE: next_state = wr_opnd ? DOU_S_CALC : DOU_S_IDLE;
            default:    next_state = DOU_S_IDLE;
        endcase
        if (stop) begin
            next_state = DOU_S_IDLE;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state <= DOU_S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // events sampled only in the evaluation cycle
    always_comb begin
        event_set = 4'h0;
        if (state == DOU_S_CALC) begin
            event_set[DOU_ST_CMP] = op_bus.hit;
            event_set[DOU_ST_OVF] = op_bus.ovf;
            event_set[DOU_ST_UDF] = op_bus.udf;
            event_set[DOU_ST_BAD] = op_bus.bad;
        end
    end

    // result register captures every evaluation
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            result <= '0;
        end else if (state == DOU_S_CALC) begin
            result <= op_bus.result;
        end
    end

    // ==========================================================
    // sticky flags; a new event wins over a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    status[gi] <= 1'b0;
                end else if (event_set[gi]) begin
                    status[gi] <= 1'b1;
                end else if (wr_clr && reg_wdata[gi]) begin
                    status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // level request while any compare, overflow or underflow flag stands and enabled
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= control[DOU_CTL_IRQ_BIT] &&
                       (|status[2:0] || |event_set[2:0]);
        end
    end

    // event link pulse is not gated by the interrupt enable
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            event_out <= 1'b0;
        end else begin
            event_out <= |event_set[2:0];
        end
    end

    assign module_stopped = stop;

    // ==========================================================
    // read port; data valid the cycle after the strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                DOU_OFS_CONTROL:  reg_rdata <= {23'h000000, control};
                DOU_OFS_STATUS:   reg_rdata <= {28'h0000000, status};
                DOU_OFS_OPERAND:  reg_rdata <= 32'(operand);
                DOU_OFS_REF_ZERO: reg_rdata <= 32'(ref_zero);
                DOU_OFS_REF_ONE:  reg_rdata <= 32'(ref_one);
                DOU_OFS_RESULT:   reg_rdata <= 32'(result);
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule : dou_unit
`default_nettype wire

/* File: dou_unit_asserts.sv */
/*
 * Port-level checker for dou_unit.
 * Assumes it is bound to dou_unit and sees only its top ports.
 */
`timescale 1ns/1ns
`default_nettype none
module dou_unit_asserts
    import dou_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  sys_rst,
    input wire logic [DOU_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata,
    input wire logic                  irq_req,
    input wire logic                  event_out,
    input wire logic                  module_stopped
);
    // ========
    // helpers
    logic ien;
    logic stp;
    logic wop;
    logic clr;

    // operand writes only count while running
    assign wop = reg_wr && reg_addr == DOU_OFS_OPERAND && !module_stopped;
    assign clr = reg_wr && reg_addr == DOU_OFS_STAT_CLR && reg_wdata[2:0] == 3'h7;

    // shadow of enable and stop bits
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ien <= 1'b0;
            stp <= 1'b1;
        end else if (reg_wr && reg_addr == DOU_OFS_CONTROL) begin
            ien <= reg_wdata[DOU_CTL_IRQ_BIT];
            stp <= reg_wdata[DOU_CTL_STOP_BIT];
        end
    end

    // ========
    // properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property ($past(reg_rd && reg_addr == 3'h7) |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_event_pulse: assert property (event_out && !$past(wop) |=> !event_out)
        else $error("event output longer than one cycle");
    a_event_cause: assert property (event_out |-> $past(wop, 2))
        else $error("event without running operand write");
    a_irq_gate: assert property (irq_req |-> ien || $past(ien))
        else $error("interrupt while disabled");
    a_irq_rise: assert property ($rose(irq_req) && $past(ien, 2) |-> event_out)
        else $error("interrupt rose without an event");
    a_stop_mirror: assert property (module_stopped == stp)
        else $error("stop state differs from control");
    a_clear_drop: assert property (clr && !$past(wop) && !$past(wop, 2) |-> ##2 !irq_req)
        else $error("interrupt kept after full clear");
endmodule : dou_unit_asserts

bind dou_unit dou_unit_asserts i_dou_unit_asserts (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .irq_req        (irq_req),
    .event_out      (event_out),
    .module_stopped (module_stopped)
);
`default_nettype wire

/* File: dou_unit_tb.sv */
/*
 * Self-checking bench for dou_unit.
 * Assumes the checker file is compiled alongside and binds itself.
 */
`timescale 1ns/1ns
`default_nettype none
module dou_unit_tb
    import dou_pkg::*;
;
    logic                  clk_sys   = 1'b0;
    logic                  sys_rst   = 1'b1;
    logic [DOU_ADDR_W-1:0] reg_addr  = '0;
    logic [31:0]           reg_wdata = '0;
    logic                  reg_wr    = 1'b0;
    logic                  reg_rd    = 1'b0;
    logic [31:0]           reg_rdata;
    logic                  irq_req;
    logic                  event_out;
    logic                  module_stopped;
    int                    failures  = 0;
    int                    checked   = 0;
    int                    evcnt     = 0;

    // ========
    // clock and event counting
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (event_out === 1'b1) evcnt <= evcnt + 1;

    dou_unit i_dou_unit (
        .clk_sys        (clk_sys),
        .sys_rst        (sys_rst),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .irq_req        (irq_req),
        .event_out      (event_out),
        .module_stopped (module_stopped)
    );

    // ========
    // bus and compare helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask : wr
    // strobes drop first, so a held write never repeats
    task automatic idle(input int n);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n - 1) @(posedge clk_sys);
    endtask : idle
    task automatic rd(input logic [2:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd
    function automatic logic [31:0] hit(input logic [2:0] c, input logic [31:0] x, r0, r1);
        case (c)
            3'h0: return 32'(x != r0);
            3'h1: return 32'(x == r0);
            3'h2: return 32'(x < r0);
            3'h3: return 32'(x > r0);
            3'h4: return 32'(r0 < x && x < r1);
            3'h5: return 32'(x < r0 || x > r1);
            default: return 32'h0;
        endcase
    endfunction : hit
    // back-to-back setup writes, then one operation
    task automatic do_op(input logic [31:0] ctl, r0, r1, x, st);
        int e0;
        e0 = evcnt;
        wr(DOU_OFS_STAT_CLR, 32'hF);
        wr(DOU_OFS_CONTROL, ctl);
        wr(DOU_OFS_REF_ZERO, r0);
        wr(DOU_OFS_REF_ONE, r1);
        wr(DOU_OFS_OPERAND, x);
        idle(4);
        rd(DOU_OFS_STATUS, st);
        chk(32'(evcnt - e0), 32'(st[2:0] != 3'h0));
        chk(32'(irq_req), 32'(ctl[7] && st[2:0] != 3'h0));
    endtask : do_op

    // ========
    // scenarios
    task automatic t_reset;
        chk(32'(module_stopped), 32'h1);
        rd(DOU_OFS_CONTROL, 32'(DOU_CTL_RESET));
        wr(DOU_OFS_OPERAND, 32'h55);
        idle(4);
        rd(DOU_OFS_OPERAND, 32'h0);
        chk(32'(evcnt), 32'h0);
        rd(3'h7, 32'h0);
    endtask : t_reset
    task automatic t_cmp;
        logic [31:0] xs [5] = '{32'h9, 32'hA, 32'hF, 32'h14, 32'h15};
        for (int c = 0; c < 6; c++) begin
            for (int i = 0; i < 5; i++) begin
                do_op(32'(c) << 4 | 32'h88, 32'hA, 32'h14, xs[i],
                      hit(3'(c), xs[i], 32'hA, 32'h14));
            end
        end
        do_op(32'h90, 32'hABCD0005, 32'h0, 32'h12340005, 32'h1);
    endtask : t_cmp
    task automatic ar(input logic [31:0] ctl, r0, x, st, res);
        do_op(ctl, r0, 32'h0, x, st);
        rd(DOU_OFS_RESULT, res);
    endtask : ar
    task automatic t_arith;
        ar(32'h81, 32'hFFFF, 32'h1, 32'h2, 32'h0);
        ar(32'h81, 32'hFFFE, 32'h1, 32'h0, 32'hFFFF);
        ar(32'h89, 32'hFFFFFFFF, 32'h1, 32'h2, 32'h0);
        ar(32'h89, 32'hFFFF, 32'h1, 32'h0, 32'h10000);
        ar(32'h82, 32'h1, 32'h0, 32'h4, 32'hFFFF);
        ar(32'h8A, 32'h1, 32'h0, 32'h4, 32'hFFFFFFFF);
        ar(32'h8A, 32'h5, 32'h5, 32'h0, 32'h0);
    endtask : t_arith
    // prohibited codes flag only, no request
    task automatic t_bad;
        do_op(32'hE8, 32'h1, 32'h2, 32'h1, 32'h8);
        do_op(32'hF8, 32'h1, 32'h2, 32'h1, 32'h8);
        do_op(32'h8B, 32'h1, 32'h2, 32'h1, 32'h8);
    endtask : t_bad
    // back-to-back operand writes each evaluate; stop freezes data
    task automatic t_burst;
        int e0;
        e0 = evcnt;
        wr(DOU_OFS_STAT_CLR, 32'hF);
        wr(DOU_OFS_CONTROL, 32'h88);
        wr(DOU_OFS_REF_ZERO, 32'h7);
        wr(DOU_OFS_OPERAND, 32'h1);
        wr(DOU_OFS_OPERAND, 32'h2);
        idle(4);
        chk(32'(evcnt - e0), 32'h2);
        rd(DOU_OFS_STATUS, 32'h1);
        wr(DOU_OFS_CONTROL, 32'h188);
        wr(DOU_OFS_REF_ZERO, 32'h33);
        wr(DOU_OFS_OPERAND, 32'h7);
        idle(4);
        chk(32'(module_stopped), 32'h1);
        chk(32'(evcnt - e0), 32'h2);
        wr(DOU_OFS_CONTROL, 32'h88);
        rd(DOU_OFS_REF_ZERO, 32'h7);
        rd(DOU_OFS_OPERAND, 32'h2);
    endtask : t_burst
    // sticky flag shows once enabled, drops on clear
    task automatic t_gate;
        do_op(32'h18, 32'h7, 32'h7, 32'h7, 32'h1);
        wr(DOU_OFS_CONTROL, 32'h98);
        idle(3);
        chk(32'(irq_req), 32'h1);
        wr(DOU_OFS_STAT_CLR, 32'hF);
        idle(3);
        chk(32'(irq_req), 32'h0);
        rd(DOU_OFS_STATUS, 32'h0);
    endtask : t_gate

    task automatic results;
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        wr(DOU_OFS_CONTROL, 32'h0);
        idle(2);
        t_cmp();
        t_arith();
        t_bad();
        t_burst();
        t_gate();
        results();
    end
    // watchdog, far beyond the expected run
    initial begin
        #(40 * 20000);
        failures++;
        results();
    end
endmodule : dou_unit_tb
`default_nettype wire
